// file: rpd_cfg.svh
/*
 * Constants of the reset and power-down controller: register indices,
 * field positions, reset values and power-down values.
 * Assumes inclusion by its bare name from the package and the top module.
 */
`ifndef RPD_CFG_SVH
`define RPD_CFG_SVH
`define RPD_AW 5
`define RPD_DW 8
`define RPD_IDX_MR 5'h00
`define RPD_IDX_W1 5'h01
`define RPD_IDX_W2 5'h02
`define RPD_IDX_W3 5'h03
`define RPD_IDX_V1 5'h04
`define RPD_IDX_I1 5'h05
`define RPD_IDX_V2 5'h06
`define RPD_IDX_PU0 5'h07
`define RPD_IDX_L1 5'h08
`define RPD_IDX_L2 5'h09
`define RPD_IDX_C1 5'h0a
`define RPD_IDX_C2 5'h0b
`define RPD_IDX_CTRL 5'h0c
`define RPD_IDX_FLAGS 5'h0d
`define RPD_IDX_A 5'h0e
`define RPD_IDX_B 5'h0f
`define RPD_IDX_SP 5'h10
`define RPD_IDX_DLAT 5'h11
`define RPD_IDX_DOE 5'h12
`define RPD_IDX_P0LAT 5'h13
`define RPD_IDX_P1LAT 5'h14
`define RPD_IDX_MODE 5'h15
`define RPD_CTRL_MASTER_IRQ_ENABLE_FLAG 0
`define RPD_CTRL_WEF 1
`define RPD_CTRL_CR 2
`define RPD_CTRL_CY 3
`define RPD_FLG_EXTERNAL0_REQUEST_FLAG 0
`define RPD_FLG_T1F 1
`define RPD_FLG_T2F 2
`define RPD_FLG_WDF 3
`define RPD_FLG_PDF 4
`define RPD_L1_LCDON 2
`define RPD_MR_RST 4'h8
`define RPD_L2_RST 4'hf
`define RPD_N4_ZERO 4'h0
`define RPD_N5_ZERO 5'h00
`define RPD_N2_ZERO 2'h0
`define RPD_D_RST 8'hff
`define RPD_D_HIZ 8'h00
`define RPD_PORT_RST 4'hf
`define RPD_SP_ZERO 3'h0
`define RPD_SP_PDN 3'h7
`define RPD_SYNC_ZERO 9'h000
`define RPD_VDROP_BIT 8
`define RPD_RD_ZERO 8'h00
`endif

// file: rpd_pkg.sv
/*
 * Types of the reset and power-down controller: operating modes and the
 * packed state of the top module.
 * Assumes rpd_cfg.svh is on the include path.
 */
`include "rpd_cfg.svh"
package rpd_pkg;
    typedef enum logic [2:0] {
        RPD_RUN = 3'b001,
        RPD_CLKOP = 3'b010,
        RPD_RAMBK = 3'b100
    } rpd_mode_t;

    typedef struct packed {
        rpd_mode_t st;
        logic hold;
        logic start;
        logic [3:0] mr;
        logic [4:0] w1;
        logic [3:0] w2;
        logic [1:0] w3;
        logic [4:0] v1;
        logic [3:0] i1;
        logic [3:0] v2;
        logic [3:0] pu0;
        logic [3:0] l1;
        logic [3:0] l2;
        logic [3:0] c1;
        logic c2;
        logic cr;
        logic [3:0] a;
        logic [3:0] b;
        logic cy;
        logic [2:0] sp;
        logic master_irq_enable_flag;
        logic external0_request_flag;
        logic t1f;
        logic t2f;
        logic watchdog_flag;
        logic watchdog_enable_flag;
        logic pdf;
        logic [7:0] dlat;
        logic [7:0] doe;
        logic [3:0] p0lat;
        logic [3:0] p1lat;
        logic [8:0] s1;
        logic [8:0] s2;
        logic [8:0] s3;
        logic [8:0] f;
        logic [7:0] rdata;
        logic main_osc;
        logic sub_osc;
        logic lcd_on;
        logic t2en;
        logic carrier_output_pin;
    } rpd_state_t;
endpackage

// file: rpd_ctrl.sv
/*
 * Reset and power-down controller of a 4-bit core: cold-start state,
 * clock-operating and RAM back-up modes, wakeup and warm-start flag.
 * Assumes a core that pulses the power-down instruction strobes on MCLK,
 * holds while CORE_HOLD is high and restarts at address zero on
 * CORE_START. Port and voltage-drop pins are asynchronous.
 */
//
// Function
// - Any reset restarts core at address zero
// - Reset floats D port, latches set one
// - Reset sets P0 and P1 latches one
// - Reset turns P1 pull-ups off
// - Reset clears master interrupt enable
// - Reset clears request, watchdog, power-down flags
// - Reset loads clock control with 1000
// - Reset clears first timer control register
// - Reset clears source enable, edge control
// - Reset clears pull-up and general nibble
// - Other state undefined; firmware must initialise
// - Two instructions enter two power-down modes
// - Clock-operating keeps sub-clock, LCD, timer 2
// - RAM back-up stops all oscillators
// - Wake: edge or timer 2; back-up edge only
// - Warm start at zero, power-down flag one
// - Cold start at zero, power-down flag zero
// - Voltage drop forces a device reset
// - Power-down entry reinitialises core, listed registers
// - Power-down retains clock, timer, LCD state
// - Watchdog flag kept only in clock-operating
// - RAM back-up turns LCD off
// - Power-down entry sets stack pointer 111
// - Software reads power-down and timer 2 flags
`timescale 1ns/1ns
`include "rpd_cfg.svh"
module rpd_ctrl
    import rpd_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Register port
    input wire logic [`RPD_AW-1:0] ADDR,
    input wire logic [`RPD_DW-1:0] WDATA,
    input wire logic WE,
    input wire logic RE,
    output logic [`RPD_DW-1:0] RDATA,
    // Core events
    input wire logic ENTER_CLKOP,
    input wire logic ENTER_RAMBK,
    input wire logic WDT_RESET,
    input wire logic WDT_FLAG_SET,
    input wire logic EXT0_REQ,
    input wire logic T1_REQ,
    input wire logic T2_UNDERFLOW,
    // Core control
    output logic CORE_HOLD,
    output logic CORE_START,
    output logic PDN_FLAG,
    output logic [2:0] STACK_PTR,
    // Pins
    input wire logic VDROP_I,
    input wire logic [3:0] P0_I,
    input wire logic [3:0] P1_I,
    output logic [7:0] D_O,
    output logic [7:0] D_OE,
    output logic [3:0] P0_O,
    output logic [3:0] P1_O,
    output logic [3:0] P1_PU,
    output logic CARRIER_OUTPUT_PIN_O,
    // Clock and display enables
    output logic MAIN_OSC_EN,
    output logic SUB_OSC_EN,
    output logic LCD_ON,
    output logic TMR2_EN
);
    // Cold-start image; left-open items get zero, l2 all ones, so simulation stays clean
    localparam rpd_state_t RST_VAL = '{
        st: RPD_RUN, hold: 1'b1, start: 1'b0,
        mr: `RPD_MR_RST, w1: `RPD_N5_ZERO, w2: `RPD_N4_ZERO,
        w3: `RPD_N2_ZERO, v1: `RPD_N5_ZERO, i1: `RPD_N4_ZERO,
        v2: `RPD_N4_ZERO, pu0: `RPD_N4_ZERO, l1: `RPD_N4_ZERO,
        l2: `RPD_L2_RST, c1: `RPD_N4_ZERO, c2: 1'b0, cr: 1'b0,
        a: `RPD_N4_ZERO, b: `RPD_N4_ZERO, cy: 1'b0, sp: `RPD_SP_ZERO,
        master_irq_enable_flag: 1'b0, external0_request_flag: 1'b0, t1f: 1'b0, t2f: 1'b0, watchdog_flag: 1'b0,
        watchdog_enable_flag: 1'b0, pdf: 1'b0, dlat: `RPD_D_RST, doe: `RPD_D_HIZ,
        p0lat: `RPD_PORT_RST, p1lat: `RPD_PORT_RST,
        s1: `RPD_SYNC_ZERO, s2: `RPD_SYNC_ZERO, s3: `RPD_SYNC_ZERO,
        f: `RPD_SYNC_ZERO, rdata: `RPD_RD_ZERO,
        main_osc: 1'b1, sub_osc: 1'b1, lcd_on: 1'b0, t2en: 1'b1,
        carrier_output_pin: 1'b0
    };

    rpd_state_t r;
    rpd_state_t n;
    logic [7:0] fall;
    logic ext_wake;
    logic cold;
    logic enter;
    logic sw_wr;

    always_comb
    begin
        n = r;
        n.rdata = `RPD_RD_ZERO;
        n.start = 1'b0;
        // Pins: change accepted once stages two and three agree
        n.s1 = {VDROP_I, P1_I, P0_I};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.f = (r.s2 & r.s3) | (r.f & (r.s2 | r.s3));
        fall = r.f[7:0] & ~n.f[7:0];
        // P1 wakes only on bits whose pull-up is on
        ext_wake = |(fall & {r.pu0, `RPD_PORT_RST});
        cold = WDT_RESET | r.f[`RPD_VDROP_BIT];
        enter = (r.st == RPD_RUN) && !r.hold &&
            (ENTER_CLKOP || ENTER_RAMBK);
        // Core is halted outside run, so writes there are dropped
        sw_wr = WE && (r.st == RPD_RUN) && !r.hold;
        if (RE)
        begin
            case (ADDR)
                `RPD_IDX_MR: n.rdata = {4'h0, r.mr};
                `RPD_IDX_W1: n.rdata = {3'h0, r.w1};
                `RPD_IDX_W2: n.rdata = {4'h0, r.w2};
                `RPD_IDX_W3: n.rdata = {6'h00, r.w3};
                `RPD_IDX_V1: n.rdata = {3'h0, r.v1};
                `RPD_IDX_I1: n.rdata = {4'h0, r.i1};
                `RPD_IDX_V2: n.rdata = {4'h0, r.v2};
                `RPD_IDX_PU0: n.rdata = {4'h0, r.pu0};
                `RPD_IDX_L1: n.rdata = {4'h0, r.l1};
                `RPD_IDX_L2: n.rdata = {4'h0, r.l2};
                `RPD_IDX_C1: n.rdata = {4'h0, r.c1};
                `RPD_IDX_C2: n.rdata = {7'h00, r.c2};
                `RPD_IDX_CTRL: n.rdata = {4'h0, r.cy, r.cr, r.watchdog_enable_flag, r.master_irq_enable_flag};
                // Warm/cold and wake source visible to firmware
                `RPD_IDX_FLAGS: n.rdata = {3'h0, r.pdf, r.watchdog_flag, r.t2f,
                    r.t1f, r.external0_request_flag};
                `RPD_IDX_A: n.rdata = {4'h0, r.a};
                `RPD_IDX_B: n.rdata = {4'h0, r.b};
                `RPD_IDX_SP: n.rdata = {5'h00, r.sp};
                `RPD_IDX_DLAT: n.rdata = r.dlat;
                `RPD_IDX_DOE: n.rdata = r.doe;
                `RPD_IDX_P0LAT: n.rdata = {4'h0, r.p0lat};
                `RPD_IDX_P1LAT: n.rdata = {4'h0, r.p1lat};
                `RPD_IDX_MODE: n.rdata = {5'h00, r.st};
                default: n.rdata = `RPD_RD_ZERO;
            endcase
        end
        if (sw_wr)
        begin
            case (ADDR)
                `RPD_IDX_MR: n.mr = WDATA[3:0];
                `RPD_IDX_W1: n.w1 = WDATA[4:0];
                `RPD_IDX_W2: n.w2 = WDATA[3:0];
                `RPD_IDX_W3: n.w3 = WDATA[1:0];
                `RPD_IDX_V1: n.v1 = WDATA[4:0];
                `RPD_IDX_I1: n.i1 = WDATA[3:0];
                `RPD_IDX_V2: n.v2 = WDATA[3:0];
                `RPD_IDX_PU0: n.pu0 = WDATA[3:0];
                `RPD_IDX_L1: n.l1 = WDATA[3:0];
                `RPD_IDX_L2: n.l2 = WDATA[3:0];
                `RPD_IDX_C1: n.c1 = WDATA[3:0];
                `RPD_IDX_C2: n.c2 = WDATA[0];
                `RPD_IDX_CTRL:
                begin
                    n.master_irq_enable_flag = WDATA[`RPD_CTRL_MASTER_IRQ_ENABLE_FLAG];
                    n.watchdog_enable_flag = WDATA[`RPD_CTRL_WEF];
                    n.cr = WDATA[`RPD_CTRL_CR];
                    n.cy = WDATA[`RPD_CTRL_CY];
                end
                `RPD_IDX_FLAGS:
                begin
                    n.external0_request_flag = r.external0_request_flag & ~WDATA[`RPD_FLG_EXTERNAL0_REQUEST_FLAG];
                    n.t1f = r.t1f & ~WDATA[`RPD_FLG_T1F];
                    n.t2f = r.t2f & ~WDATA[`RPD_FLG_T2F];
                    n.watchdog_flag = r.watchdog_flag & ~WDATA[`RPD_FLG_WDF];
                end
                `RPD_IDX_A: n.a = WDATA[3:0];
                `RPD_IDX_B: n.b = WDATA[3:0];
                `RPD_IDX_SP: n.sp = WDATA[2:0];
                `RPD_IDX_DLAT: n.dlat = WDATA;
                `RPD_IDX_DOE: n.doe = WDATA;
                `RPD_IDX_P0LAT: n.p0lat = WDATA[3:0];
                `RPD_IDX_P1LAT: n.p1lat = WDATA[3:0];
                default: n.mr = r.mr;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        n.external0_request_flag = n.external0_request_flag | EXT0_REQ;
        n.t1f = n.t1f | T1_REQ;
        n.t2f = n.t2f | T2_UNDERFLOW;
        n.watchdog_flag = n.watchdog_flag | WDT_FLAG_SET;
        case (r.st)
            RPD_RUN:
            begin
                if (enter)
                begin
                    // Clock-operating wins if both strobes come together
                    n.st = ENTER_CLKOP ? RPD_CLKOP : RPD_RAMBK;
                    n.hold = 1'b1;
                    n.pdf = 1'b1;
                    n.sp = `RPD_SP_PDN;
                    n.a = `RPD_N4_ZERO;
                    n.b = `RPD_N4_ZERO;
                    n.cy = 1'b0;
                    n.w1 = `RPD_N5_ZERO;
                    n.v1 = `RPD_N5_ZERO;
                    n.c1 = `RPD_N4_ZERO;
                    n.c2 = 1'b0;
                    n.cr = 1'b0;
                    n.external0_request_flag = 1'b0;
                    n.t1f = 1'b0;
                    n.master_irq_enable_flag = 1'b0;
                    n.v2 = `RPD_N4_ZERO;
                    if (!ENTER_CLKOP)
                    begin
                        n.watchdog_flag = 1'b0;
                    end
                end
                else if (r.hold)
                begin
                    // Restart pulse tells the core to load address zero
                    n.hold = 1'b0;
                    n.start = 1'b1;
                end
            end
            RPD_CLKOP:
            begin
                // A pending timer 2 request returns at once
                if (ext_wake || r.t2f || T2_UNDERFLOW)
                begin
                    n.st = RPD_RUN;
                end
            end
            RPD_RAMBK:
            begin
                if (ext_wake)
                begin
                    n.st = RPD_RUN;
                end
            end
            default:
            begin
                n.st = RPD_RUN;
                n.hold = 1'b1;
            end
        endcase
        n.main_osc = (n.st == RPD_RUN);
        n.sub_osc = (n.st != RPD_RAMBK);
        n.t2en = (n.st != RPD_RAMBK);
        n.lcd_on = n.l1[`RPD_L1_LCDON] && (n.st != RPD_RAMBK);
        n.carrier_output_pin = n.cr & n.c2;
        if (cold)
        begin
            // Cold source overrides any wakeup; pin stages keep running
            n = RST_VAL;
            n.s1 = {VDROP_I, P1_I, P0_I};
            n.s2 = r.s1;
            n.s3 = r.s2;
            n.f = (r.s2 & r.s3) | (r.f & (r.s2 | r.s3));
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            r <= RST_VAL;
        end
        else
        begin
            r <= n;
        end
    end

    assign RDATA = r.rdata;
    assign CORE_HOLD = r.hold;
    assign CORE_START = r.start;
    assign PDN_FLAG = r.pdf;
    assign STACK_PTR = r.sp;
    assign D_O = r.dlat;
    assign D_OE = r.doe;
    assign P0_O = r.p0lat;
    assign P1_O = r.p1lat;
    assign P1_PU = r.pu0;
    assign CARRIER_OUTPUT_PIN_O = r.carrier_output_pin;
    assign MAIN_OSC_EN = r.main_osc;
    assign SUB_OSC_EN = r.sub_osc;
    assign LCD_ON = r.lcd_on;
    assign TMR2_EN = r.t2en;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    sequence s_cold;
        WDT_RESET;
    endsequence
    sequence s_enter;
        (r.st == RPD_RUN) && !r.hold && (ENTER_CLKOP || ENTER_RAMBK)
            && !cold;
    endsequence
    sequence s_enter_ram;
        s_enter ##0 !ENTER_CLKOP;
    endsequence

    chk_cold_reset_state: assert property (s_cold |=> CORE_HOLD &&
        !PDN_FLAG && (D_OE == 8'h00) && (D_O == 8'hff) && (P1_PU == 4'h0)
        && (r.mr == 4'h8) && !r.master_irq_enable_flag && (r.v1 == 5'h00)
        ##1 CORE_START && !CORE_HOLD)
        else $error("cold start state wrong");
    chk_cold_beats_wake: assert property ((r.st != RPD_RUN) &&
        WDT_RESET |=> (r.st == RPD_RUN) && !PDN_FLAG)
        else $error("wakeup beat cold reset");
    chk_enter_reinit: assert property (s_enter |=>
        (r.w1 == 5'h00) && (r.v2 == 4'h0) && !r.master_irq_enable_flag && !r.t1f
        && (r.a == 4'h0) && !r.cy && CORE_HOLD)
        else $error("power-down entry did not reinitialise");
    chk_enter_sp_flag: assert property (s_enter |=>
        (STACK_PTR == 3'h7) && PDN_FLAG)
        else $error("stack pointer or flag not set on entry");
    chk_enter_retain: assert property (s_enter ##0 !WE |=>
        $stable(r.mr) && $stable(r.l2) && $stable(r.watchdog_enable_flag) && $stable(r.w2))
        else $error("retained state changed on entry");
    chk_ram_wdf_clear: assert property (s_enter_ram |=>
        !r.watchdog_flag && (r.st == RPD_RAMBK))
        else $error("watchdog flag kept in back-up");
    chk_ram_clocks_off: assert property ((r.st == RPD_RAMBK)
        [*2] |-> !MAIN_OSC_EN && !SUB_OSC_EN && !LCD_ON && !TMR2_EN)
        else $error("clocks or display on in back-up");
    chk_clkop_running: assert property ((r.st == RPD_CLKOP)
        [*2] |-> SUB_OSC_EN && TMR2_EN && !MAIN_OSC_EN
        && (LCD_ON == r.l1[`RPD_L1_LCDON]))
        else $error("clock-operating lost sub-clock");
    chk_ram_no_timer: assert property ((r.st == RPD_RAMBK) &&
        !ext_wake && !cold |=> (r.st == RPD_RAMBK))
        else $error("back-up left without edge");
    chk_clkop_t2_wake: assert property ((r.st == RPD_CLKOP) &&
        T2_UNDERFLOW && !cold |=> (r.st == RPD_RUN) ##1 CORE_START
        && PDN_FLAG)
        else $error("timer 2 wake missing");
endmodule

// file: rpd_ctrl_bench.sv
/*
 * Self-checking bench of the reset and power-down controller: cold image,
 * both power-down modes, wakeup sources, watchdog and voltage-drop resets.
 * Assumes rpd_pkg and rpd_cfg.svh are compiled first; drives every port.
 */
`timescale 1ns/1ns
`include "rpd_cfg.svh"
module rpd_ctrl_bench
    import rpd_pkg::*;
;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [4:0] ADDR = 5'h00;
    logic [7:0] WDATA = 8'h00, RDATA, D_O, D_OE;
    logic WE = 1'b0, RE = 1'b0, ENTER_CLKOP = 1'b0, ENTER_RAMBK = 1'b0;
    logic WDT_RESET = 1'b0, WDT_FLAG_SET = 1'b0, EXT0_REQ = 1'b0;
    logic T1_REQ = 1'b0, T2_UNDERFLOW = 1'b0, VDROP_I = 1'b0;
    logic [3:0] P0_I = 4'hf, P1_I = 4'hf, P0_O, P1_O, P1_PU;
    logic CORE_HOLD, CORE_START, PDN_FLAG, CARRIER_OUTPUT_PIN_O;
    logic MAIN_OSC_EN, SUB_OSC_EN, LCD_ON, TMR2_EN;
    logic [2:0] STACK_PTR;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    // Values written before power-down and expected after wakeup
    logic [4:0] ra [16] = '{`RPD_IDX_MR, `RPD_IDX_W1, `RPD_IDX_W2,
        `RPD_IDX_W3, `RPD_IDX_V1, `RPD_IDX_I1, `RPD_IDX_V2, `RPD_IDX_L1,
        `RPD_IDX_L2, `RPD_IDX_C1, `RPD_IDX_C2, `RPD_IDX_CTRL,
        `RPD_IDX_DLAT, `RPD_IDX_DOE, `RPD_IDX_A, `RPD_IDX_B};
    logic [7:0] rw [16] = '{8'h09, 8'h1f, 8'h05, 8'h02, 8'h1f, 8'h0a,
        8'h09, 8'h04, 8'h03, 8'h06, 8'h01, 8'h0f, 8'h5a, 8'hff, 8'h05, 8'h06};
    logic [7:0] rx [16] = '{8'h09, 8'h00, 8'h05, 8'h02, 8'h00, 8'h0a,
        8'h00, 8'h04, 8'h03, 8'h00, 8'h00, 8'h02, 8'h5a, 8'hff, 8'h00, 8'h00};

    rpd_ctrl i_dut (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WE(WE), .RE(RE), .RDATA(RDATA), .ENTER_CLKOP(ENTER_CLKOP),
        .ENTER_RAMBK(ENTER_RAMBK), .WDT_RESET(WDT_RESET),
        .WDT_FLAG_SET(WDT_FLAG_SET), .EXT0_REQ(EXT0_REQ), .T1_REQ(T1_REQ),
        .T2_UNDERFLOW(T2_UNDERFLOW), .CORE_HOLD(CORE_HOLD),
        .CORE_START(CORE_START), .PDN_FLAG(PDN_FLAG), .STACK_PTR(STACK_PTR),
        .VDROP_I(VDROP_I), .P0_I(P0_I), .P1_I(P1_I), .D_O(D_O), .D_OE(D_OE),
        .P0_O(P0_O), .P1_O(P1_O), .P1_PU(P1_PU), .CARRIER_OUTPUT_PIN_O(CARRIER_OUTPUT_PIN_O),
        .MAIN_OSC_EN(MAIN_OSC_EN), .SUB_OSC_EN(SUB_OSC_EN), .LCD_ON(LCD_ON),
        .TMR2_EN(TMR2_EN));

    always #10 MCLK = ~MCLK;

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Ceiling well above the roughly 180 cycles the sequence needs
    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge MCLK);
        WE <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WE <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rck(input logic [4:0] a, input logic [7:0] e);
        @(posedge MCLK);
        RE <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RE <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, RDATA);
    endtask

    // Bounded wait for the restart pulse, then the flag it leaves
    task automatic wait_start(input logic pdf);
        int n;
        for (n = 0; n < 40; n++)
        begin
            @(posedge MCLK);
            #1;
            if (CORE_START === 1'b1)
                break;
        end
        chk("restart pulse", 8'h01, {7'h0, CORE_START});
        chk("power-down flag", {7'h0, pdf}, {7'h0, PDN_FLAG});
    endtask

    task automatic pd_enter(input logic bk);
        @(posedge MCLK);
        if (bk)
            ENTER_RAMBK <= 1'b1;
        else
            ENTER_CLKOP <= 1'b1;
        @(posedge MCLK);
        ENTER_RAMBK <= 1'b0;
        ENTER_CLKOP <= 1'b0;
        #1 chk("hold", 8'h01, {7'h0, CORE_HOLD});
        chk("power-down flag", 8'h01, {7'h0, PDN_FLAG});
        chk("stack", 8'h07, {5'h0, STACK_PTR});
        chk("osc main sub tmr2", {5'h0, 1'b0, !bk, !bk},
            {5'h0, MAIN_OSC_EN, SUB_OSC_EN, TMR2_EN});
    endtask

    task automatic wake_t2();
        @(posedge MCLK);
        T2_UNDERFLOW <= 1'b1;
        @(posedge MCLK);
        T2_UNDERFLOW <= 1'b0;
        #1 chk("main osc back", 8'h01, {7'h0, MAIN_OSC_EN});
        @(posedge MCLK);
        #1 chk("hold released", 8'h00, {7'h0, CORE_HOLD});
        chk("restart", 8'h01, {7'h0, CORE_START});
    endtask

    task automatic t_reset_image();
        repeat (10) @(posedge MCLK);
        chk("D latch", 8'hff, D_O);
        chk("D enable", 8'h00, D_OE);
        chk("P0 P1 latch", 8'hff, {P0_O, P1_O});
        chk("P1 pull-up", 8'h00, {4'h0, P1_PU});
        chk("carrier pin", 8'h00, {7'h0, CARRIER_OUTPUT_PIN_O});
        RST <= 1'b0;
        wait_start(1'b0);
        rck(`RPD_IDX_MR, 8'h08);
        rck(`RPD_IDX_CTRL, 8'h00);
        rck(`RPD_IDX_FLAGS, 8'h00);
        rck(`RPD_IDX_W1, 8'h00);
        rck(`RPD_IDX_V1, 8'h00);
        rck(`RPD_IDX_I1, 8'h00);
        rck(`RPD_IDX_PU0, 8'h00);
        rck(`RPD_IDX_V2, 8'h00);
        wr(`RPD_IDX_MODE, 8'h04);
        rck(`RPD_IDX_MODE, 8'h01);
        rck(5'h1f, 8'h00);
    endtask

    task automatic t_clock_operating();
        int i;
        for (i = 0; i < 16; i++)
            wr(ra[i], rw[i]);
        @(posedge MCLK);
        EXT0_REQ <= 1'b1;
        T1_REQ <= 1'b1;
        WDT_FLAG_SET <= 1'b1;
        @(posedge MCLK);
        EXT0_REQ <= 1'b0;
        T1_REQ <= 1'b0;
        WDT_FLAG_SET <= 1'b0;
        rck(`RPD_IDX_FLAGS, 8'h0b);
        chk("carrier on", 8'h01, {7'h0, CARRIER_OUTPUT_PIN_O});
        pd_enter(1'b0);
        chk("lcd kept", 8'h01, {7'h0, LCD_ON});
        chk("carrier off", 8'h00, {7'h0, CARRIER_OUTPUT_PIN_O});
        wake_t2();
        for (i = 0; i < 16; i++)
            rck(ra[i], rx[i]);
        rck(`RPD_IDX_FLAGS, 8'h1c);
        rck(`RPD_IDX_SP, 8'h07);
        chk("D pins kept", 8'h5a, D_O);
    endtask

    task automatic t_ram_backup();
        wr(`RPD_IDX_FLAGS, 8'h04);
        @(posedge MCLK);
        WDT_FLAG_SET <= 1'b1;
        @(posedge MCLK);
        WDT_FLAG_SET <= 1'b0;
        pd_enter(1'b1);
        chk("lcd off", 8'h00, {7'h0, LCD_ON});
        @(posedge MCLK);
        T2_UNDERFLOW <= 1'b1;
        @(posedge MCLK);
        T2_UNDERFLOW <= 1'b0;
        repeat (10) @(posedge MCLK);
        chk("no timer wake", 8'h01, {7'h0, CORE_HOLD});
        P0_I <= 4'he;
        wait_start(1'b1);
        @(posedge MCLK);
        P0_I <= 4'hf;
        // Underflow pulse still latches its request while stopped
        rck(`RPD_IDX_FLAGS, 8'h14);
    endtask

    // Cold source in the same cycle as a wakeup must win
    task automatic t_watchdog_cold();
        wr(`RPD_IDX_FLAGS, 8'h04);
        pd_enter(1'b0);
        @(posedge MCLK);
        WDT_RESET <= 1'b1;
        T2_UNDERFLOW <= 1'b1;
        @(posedge MCLK);
        WDT_RESET <= 1'b0;
        T2_UNDERFLOW <= 1'b0;
        #1 chk("flag after watchdog", 8'h00, {7'h0, PDN_FLAG});
        chk("hold after watchdog", 8'h01, {7'h0, CORE_HOLD});
        wait_start(1'b0);
        rck(`RPD_IDX_MR, 8'h08);
    endtask

    task automatic t_voltage_drop();
        // P1 bit with its pull-up on wakes clock-operating mode
        wr(`RPD_IDX_PU0, 8'h01);
        pd_enter(1'b0);
        @(posedge MCLK);
        P1_I <= 4'he;
        wait_start(1'b1);
        @(posedge MCLK);
        P1_I <= 4'hf;
        chk("P1 pull-up kept", 8'h01, {4'h0, P1_PU});
        pd_enter(1'b0);
        wake_t2();
        wr(`RPD_IDX_V2, 8'h0c);
        @(posedge MCLK);
        VDROP_I <= 1'b1;
        repeat (8) @(posedge MCLK);
        chk("hold in drop", 8'h01, {7'h0, CORE_HOLD});
        VDROP_I <= 1'b0;
        wait_start(1'b0);
        rck(`RPD_IDX_V2, 8'h00);
    endtask

    initial
    begin
        t_reset_image();
        t_clock_operating();
        t_ram_backup();
        t_watchdog_cold();
        t_voltage_drop();
        wrap_up();
    end
endmodule
